// file: line_state_pkg.sv
// package: line state encodings, geometry and bus carrier types
package line_state_pkg;
   localparam int LINES = 8;
   localparam int IDX_W = 3;
   localparam int TAG_W = 25;
   localparam int WORDS = 4;
   localparam int WORD_W = 32;
   localparam int WSEL_W = 2;
   localparam int ADDR_W = 30;
   localparam int IDX_LSB = 2;
   localparam int TAG_LSB = 5;
   localparam logic [1:0] ST_INVALID = 2'h0;
   localparam logic [1:0] ST_EXCLUSIVE = 2'h1;
   localparam logic [1:0] ST_MODIFIED = 2'h2;
   localparam logic [1:0] ST_SHARED = 2'h3;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] data;
   } access_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] data;
      logic write_read;
   } bus_req_type;
endpackage

// file: writeback_cache_line_state.sv
// line-state control of a small direct-mapped unified cache with mesi states
// How it works
// R1 - policy select high at hard reset selects write-back mode
// R2 - in write-back mode policy select sampled with ready or first burst ready
// R3 - that sample low marks line write-through, high marks write-back
// R4 - policy select low at reset makes every later fill write-through
// R5 - write/read indicator high for write bus cycles, low for reads
// R6 - each tag entry holds two status bits beside its address tag
// R7 - each line holds four 32-bit words sharing one tag
// R8 - status 00 invalid, 01 exclusive, 10 modified, 11 shared
// R9 - lines allocated on read misses only, never on write misses
// R10 - write hit to shared line updates cache and goes to the bus
// R11 - write hit to exclusive or modified line stays in cache only
// R12 - write to invalid or absent line goes to bus, cache untouched
// R13 - modified line written out on replacement and on snoop hit
// R14 - snoop hit on modified line backs other master off during write-back
// R15 - read hitting a valid tag is served from cache
// R16 - invalid lines take no part in snoop hits or write-backs
// R17 - write-through writes to valid lines update cache and bus
// R18 - write-through lines are kept in the shared state
// R19 - reload with page flag 0: exclusive if policy sampled 1, else shared
// R20 - reload with page flag 1 forces the shared state
// R21 - write hit on exclusive line makes it modified, no bus activity
//
// Implementation choices: the plain strobed port.
module writeback_cache_line_state
   import line_state_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic cpu_rd_i,
   input wire logic cpu_wr_i,
   input wire access_type cpu_req_i,
   output logic cpu_done_o,
   output logic [WORD_W-1:0] cpu_rdata_o,
   output logic bus_start_o,
   output bus_req_type bus_req_o,
   output logic bus_burst_o,
   input wire logic ready_n_i,
   input wire logic burst_ready_n_i,
   input wire logic [WORD_W-1:0] bus_rdata_i,
   input wire logic line_policy_select_i,
   input wire logic page_write_through_flag_i,
   input wire logic snoop_start_i,
   input wire logic snoop_inv_i,
   input wire logic [ADDR_W-1:0] snoop_addr_i,
   output logic snoop_hit_modified_o,
   output logic backoff_o,
   output logic writeback_mode_o,
   output logic supply_level_indicator_o
);
   typedef enum logic [2:0] {
      S_IDLE, S_WR_BUS, S_EVICT, S_FILL, S_SNOOP_WB, S_DONE
   } fsm_type;

   function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
      return a[TAG_LSB-1:IDX_LSB];
   endfunction
   function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:TAG_LSB];
   endfunction
   // only a valid line can hit, be snooped or be written back [R16]
   function automatic logic line_valid(input logic [1:0] st);
      return st != ST_INVALID;
   endfunction
   // exclusive and modified lines take writes without the bus [R11]
   function automatic logic line_private(input logic [1:0] st);
      return (st == ST_EXCLUSIVE) || (st == ST_MODIFIED);
   endfunction
   // a dirty line must reach memory before it is reused or snooped [R13]
   function automatic logic line_dirty(input logic [1:0] st);
      return st == ST_MODIFIED;
   endfunction

   // pin synchronisers, first stage read by second only
   // ready, data and policy share one delay, so they stay aligned
   logic rdy_s1_ff, rdy_s2_ff, burst_ready_s1_ff, burst_ready_s2_ff, pol_s1_ff, pol_s2_ff;
   logic pwt_s1_ff, pwt_s2_ff, snp_s1_ff, snp_s2_ff, inv_s1_ff, inv_s2_ff;
   logic [ADDR_W-1:0] saddr_s1_ff, saddr_s2_ff;
   logic [WORD_W-1:0] rdat_s1_ff, rdat_s2_ff;
   // strap sampled once the policy pin has crossed both sync stages
   localparam logic [1:0] STRAP_EDGES = 2'h3;
   logic [1:0] strap_cnt_ff;
   // snoop request parked until the idle machine can look at it
   logic snoop_pend_ff, snoop_inv_ff, wb_inv_ff, supply_ff;
   logic [ADDR_W-1:0] snoop_addr_ff;

   // tag array and data [R6] [R7]
   logic [TAG_W-1:0] tag_ff [LINES];
   logic [1:0] state_ff [LINES]; // [R8]
   logic [WORD_W-1:0] data_ff [LINES][WORDS];

   // control state and bus request registers
   fsm_type fsm_ff;
   logic wb_mode_ff;
   logic first_rdy_ff;
   logic fill_wb_ff;
   logic [WSEL_W-1:0] beat_ff;
   logic [IDX_W-1:0] snoop_idx_ff;
   logic cpu_done_ff, bus_start_ff, bus_burst_ff, hitm_ff, boff_ff;
   logic [WORD_W-1:0] cpu_rdata_ff;
   bus_req_type bus_req_ff;

   wire logic [IDX_W-1:0] cidx = idx_of(cpu_req_i.addr);
   wire logic [WSEL_W-1:0] cword = cpu_req_i.addr[WSEL_W-1:0];
   wire logic [1:0] cstate = state_ff[cidx];
   wire logic chit = line_valid(cstate) && (tag_ff[cidx] == tag_of(cpu_req_i.addr));
   wire logic [IDX_W-1:0] sidx = idx_of(snoop_addr_ff);
   wire logic [1:0] sstate = state_ff[sidx];
   // invalid lines never hit a snoop [R16]
   wire logic shit = line_valid(sstate) && (tag_ff[sidx] == tag_of(snoop_addr_ff));

   // idle decisions: a snoop hit goes before any cpu request
   wire logic snoop_take = snoop_pend_ff && shit;
   wire logic rd_hit = cpu_rd_i && chit; // [R15]
   wire logic wr_private = cpu_wr_i && chit && line_private(cstate); // [R11]

   // ready arrives through the sync stages, two cycles after the pin
   wire logic ready_seen = !rdy_s2_ff || !burst_ready_s2_ff;
   wire logic victim_dirty = line_dirty(cstate);
   // reload state: page flag overrides, write-through fills shared [R18] [R19] [R20]
   // page flag taken from its sync stage, in step with the last ready
   wire logic [1:0] fill_state = (pwt_s2_ff || !fill_wb_ff) ?
                                 ST_SHARED : ST_EXCLUSIVE;
   // write-back source: the snooped line or the victim
   wire logic [IDX_W-1:0] widx = (fsm_ff == S_SNOOP_WB) ? snoop_idx_ff : cidx;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdy_s1_ff <= 1'b1;
         rdy_s2_ff <= 1'b1;
         burst_ready_s1_ff <= 1'b1;
         burst_ready_s2_ff <= 1'b1;
         pol_s1_ff <= 1'b0;
         pol_s2_ff <= 1'b0;
         pwt_s1_ff <= 1'b0;
         pwt_s2_ff <= 1'b0;
         snp_s1_ff <= 1'b0;
         snp_s2_ff <= 1'b0;
         inv_s1_ff <= 1'b0;
         inv_s2_ff <= 1'b0;
         saddr_s1_ff <= '0;
         saddr_s2_ff <= '0;
         rdat_s1_ff <= '0;
         rdat_s2_ff <= '0;
      end else begin
         rdy_s1_ff <= ready_n_i;
         rdy_s2_ff <= rdy_s1_ff;
         burst_ready_s1_ff <= burst_ready_n_i;
         burst_ready_s2_ff <= burst_ready_s1_ff;
         pol_s1_ff <= line_policy_select_i;
         pol_s2_ff <= pol_s1_ff;
         pwt_s1_ff <= page_write_through_flag_i;
         pwt_s2_ff <= pwt_s1_ff;
         snp_s1_ff <= snoop_start_i;
         snp_s2_ff <= snp_s1_ff;
         inv_s1_ff <= snoop_inv_i;
         inv_s2_ff <= inv_s1_ff;
         saddr_s1_ff <= snoop_addr_i;
         saddr_s2_ff <= saddr_s1_ff;
         rdat_s1_ff <= bus_rdata_i;
         rdat_s2_ff <= rdat_s1_ff;
      end
   end

   // mode strap: policy pin seen through both sync stages after release,
   // so the reset value of the stages never becomes the mode
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         strap_cnt_ff <= 2'h0;
         wb_mode_ff <= 1'b0;
      end else if (strap_cnt_ff != STRAP_EDGES) begin
         strap_cnt_ff <= strap_cnt_ff + 2'h1;
         if (strap_cnt_ff == STRAP_EDGES - 2'h1) begin
            wb_mode_ff <= pol_s2_ff; // [R1] [R4]
         end
      end
   end

   // snoop held until the idle machine looks at it, so a snoop that lands
   // during a cpu transfer is answered afterwards instead of being dropped;
   // the system must keep the snoop address steady while the strobe syncs
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         snoop_pend_ff <= 1'b0;
         snoop_inv_ff <= 1'b0;
         snoop_addr_ff <= '0;
      end else if (snp_s2_ff) begin
         snoop_pend_ff <= 1'b1;
         snoop_inv_ff <= inv_s2_ff;
         snoop_addr_ff <= saddr_s2_ff;
      end else if (fsm_ff == S_IDLE) begin
         snoop_pend_ff <= 1'b0;
      end
   end

   // control state machine
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fsm_ff <= S_IDLE;
         first_rdy_ff <= 1'b0;
         fill_wb_ff <= 1'b0;
         beat_ff <= '0;
         snoop_idx_ff <= '0;
         wb_inv_ff <= 1'b0;
         cpu_done_ff <= 1'b0;
         cpu_rdata_ff <= '0;
         bus_start_ff <= 1'b0;
         bus_burst_ff <= 1'b0;
         bus_req_ff <= '0;
         hitm_ff <= 1'b0;
         boff_ff <= 1'b0;
         for (int i = 0; i < LINES; i++) begin
            state_ff[i] <= ST_INVALID;
            tag_ff[i] <= '0;
         end
      end else begin
         // strobes last one cycle unless set again below
         cpu_done_ff <= 1'b0;
         bus_start_ff <= 1'b0;
         hitm_ff <= 1'b0;
         case (fsm_ff)
            S_IDLE: begin
               if (snoop_take) begin
                  snoop_idx_ff <= sidx;
                  wb_inv_ff <= snoop_inv_ff;
                  if (line_dirty(sstate)) begin
                     // other master backed off while line goes out [R13] [R14]
                     hitm_ff <= 1'b1;
                     boff_ff <= 1'b1;
                     beat_ff <= '0;
                     bus_req_ff.addr <= {tag_ff[sidx], sidx, 2'h0};
                     bus_req_ff.data <= data_ff[sidx][0];
                     bus_req_ff.write_read <= 1'b1; // [R5]
                     bus_start_ff <= 1'b1;
                     bus_burst_ff <= 1'b1;
                     fsm_ff <= S_SNOOP_WB;
                  end else if (snoop_inv_ff) begin
                     state_ff[sidx] <= ST_INVALID;
                  end else begin
                     state_ff[sidx] <= ST_SHARED;
                  end
               end else if (rd_hit) begin
                  cpu_rdata_ff <= data_ff[cidx][cword]; // [R15]
                  cpu_done_ff <= 1'b1;
                  fsm_ff <= S_DONE;
               end else if (cpu_rd_i) begin
                  // read miss allocates; dirty victim copied out first [R9] [R13]
                  beat_ff <= '0;
                  first_rdy_ff <= 1'b1;
                  bus_start_ff <= 1'b1;
                  bus_burst_ff <= 1'b1;
                  if (victim_dirty) begin
                     bus_req_ff.addr <= {tag_ff[cidx], cidx, 2'h0};
                     bus_req_ff.data <= data_ff[cidx][0];
                     bus_req_ff.write_read <= 1'b1; // [R5]
                     fsm_ff <= S_EVICT;
                  end else begin
                     bus_req_ff.addr <= {cpu_req_i.addr[ADDR_W-1:WSEL_W], 2'h0};
                     bus_req_ff.data <= '0;
                     bus_req_ff.write_read <= 1'b0; // [R5]
                     fsm_ff <= S_FILL;
                  end
               end else if (cpu_wr_i) begin
                  if (wr_private) begin
                     // cache only; exclusive becomes modified [R11] [R21]
                     state_ff[cidx] <= ST_MODIFIED;
                     cpu_done_ff <= 1'b1;
                     fsm_ff <= S_DONE;
                  end else begin
                     // shared hit or miss: out to bus, no allocation [R10] [R12] [R17]
                     bus_req_ff <= '{addr: cpu_req_i.addr, data: cpu_req_i.data,
                                     write_read: 1'b1};
                     bus_start_ff <= 1'b1;
                     bus_burst_ff <= 1'b0;
                     fsm_ff <= S_WR_BUS;
                  end
               end
            end
            // done only once memory has taken the word
            S_WR_BUS: begin
               if (ready_seen) begin
                  cpu_done_ff <= 1'b1;
                  fsm_ff <= S_DONE;
               end
            end
            S_EVICT, S_SNOOP_WB: begin
               if (ready_seen) begin
                  beat_ff <= beat_ff + 2'h1;
                  // next word staged as soon as the current one is taken
                  bus_req_ff.data <= data_ff[widx][beat_ff + 2'h1];
                  bus_req_ff.addr <= {bus_req_ff.addr[ADDR_W-1:WSEL_W], beat_ff + 2'h1};
                  if (beat_ff == 2'h3) begin
                     bus_burst_ff <= 1'b0;
                     beat_ff <= '0;
                     if (fsm_ff == S_SNOOP_WB) begin
                        state_ff[snoop_idx_ff] <= wb_inv_ff ? ST_INVALID : ST_SHARED;
                        boff_ff <= 1'b0;
                        fsm_ff <= S_IDLE;
                     end else begin
                        // victim stays modified until overwritten by the fill
                        bus_req_ff.addr <= {cpu_req_i.addr[ADDR_W-1:WSEL_W], 2'h0};
                        bus_req_ff.write_read <= 1'b0;
                        bus_start_ff <= 1'b1;
                        bus_burst_ff <= 1'b1;
                        fsm_ff <= S_FILL;
                     end
                  end
               end
            end
            S_FILL: begin
               if (ready_seen) begin
                  if (first_rdy_ff) begin
                     // policy sampled with first ready only [R2] [R3] [R4]
                     fill_wb_ff <= wb_mode_ff && pol_s2_ff;
                     first_rdy_ff <= 1'b0;
                  end
                  beat_ff <= beat_ff + 2'h1;
                  if (beat_ff == 2'h3) begin
                     tag_ff[cidx] <= tag_of(cpu_req_i.addr);
                     state_ff[cidx] <= fill_state; // [R3] [R19] [R20]
                     bus_burst_ff <= 1'b0;
                     cpu_rdata_ff <= (cword == 2'h3) ? rdat_s2_ff :
                                     data_ff[cidx][cword];
                     cpu_done_ff <= 1'b1;
                     fsm_ff <= S_DONE;
                  end
               end
            end
            // request must drop before the next one is taken
            S_DONE: begin
               if (!cpu_rd_i && !cpu_wr_i) begin
                  fsm_ff <= S_IDLE;
               end
            end
            // unused codes fall back to idle
            default: begin
               fsm_ff <= S_IDLE;
            end
         endcase
      end
   end

   // data store: fill beats, write hits update cache [R7] [R10] [R11] [R17]
   // no reset: words are read only once the line state says valid
   wire logic fill_beat = (fsm_ff == S_FILL) && ready_seen;
   wire logic wr_hit = (fsm_ff == S_IDLE) && !snoop_take && !cpu_rd_i &&
                       cpu_wr_i && chit;
   always_ff @(posedge sys_clk_i) begin
      if (fill_beat) begin
         data_ff[cidx][beat_ff] <= rdat_s2_ff;
      end else if (wr_hit) begin
         data_ff[cidx][cword] <= cpu_req_i.data;
      end
   end

   assign cpu_done_o = cpu_done_ff;
   assign cpu_rdata_o = cpu_rdata_ff;
   assign bus_start_o = bus_start_ff;
   assign bus_req_o = bus_req_ff;
   assign bus_burst_o = bus_burst_ff;
   assign snoop_hit_modified_o = hitm_ff;
   assign backoff_o = boff_ff;
   assign writeback_mode_o = wb_mode_ff;
   assign supply_level_indicator_o = supply_ff;

   // supply indicator: one fixed supply level, kept in a flop so that
   // every output leaves from a register
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         supply_ff <= 1'b0;
      end else begin
         supply_ff <= 1'b0;
      end
   end
endmodule

// file: writeback_cache_line_state_monitor.sv
// checker: port-level properties of the line-state block
module line_state_monitor
   import line_state_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic cpu_rd_i,
   input wire logic cpu_wr_i,
   input wire logic cpu_done_o,
   input wire logic bus_start_o,
   input wire bus_req_type bus_req_o,
   input wire logic bus_burst_o,
   input wire logic snoop_hit_modified_o,
   input wire logic backoff_o,
   input wire logic writeback_mode_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   logic [2:0] since_ff;
   logic wr_seen_ff;
   wire logic nxt_wr_seen;
   // cleared when idle so a stray snoop write cannot satisfy a later write
   assign nxt_wr_seen = (bus_start_o && bus_req_o.write_read) ? 1'b1 :
      (cpu_done_o || !(cpu_rd_i || cpu_wr_i)) ? 1'b0 : wr_seen_ff;
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         since_ff <= 3'h0;
         wr_seen_ff <= 1'b0;
      end else begin
         since_ff <= (since_ff == 3'h7) ? since_ff : since_ff + 3'h1;
         wr_seen_ff <= nxt_wr_seen;
      end
   end
   mode_fixed_a: assert property (since_ff == 3'h7 |-> $stable(writeback_mode_o))
      else $error("cache mode changed after reset");
   wt_write_bus_a: assert property (cpu_done_o && cpu_wr_i && !writeback_mode_o |-> wr_seen_ff)
      else $error("write-through write finished without bus write");
   wr_cycle_kind_a: assert property (bus_start_o && cpu_wr_i && !backoff_o
      |-> bus_req_o.write_read && !bus_burst_o) else $error("cpu write started wrong cycle");
   rd_fill_burst_a: assert property (bus_start_o && cpu_rd_i && !bus_req_o.write_read
      |-> bus_burst_o) else $error("read cycle is not a line burst");
   hitm_pulse_a: assert property (snoop_hit_modified_o |=> !snoop_hit_modified_o)
      else $error("snoop hit pulse too long");
   hitm_backoff_a: assert property (snoop_hit_modified_o |-> ##[0:4] backoff_o)
      else $error("no backoff after snoop hit");
   backoff_wb_a: assert property ($rose(backoff_o)
      |-> ##[0:6] (bus_start_o && bus_req_o.write_read && bus_burst_o))
      else $error("no write-back burst during backoff");
   done_pulse_a: assert property (cpu_done_o |=> !cpu_done_o)
      else $error("done longer than one cycle");
endmodule
bind writeback_cache_line_state line_state_monitor line_state_monitor_i (
   .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cpu_rd_i(cpu_rd_i), .cpu_wr_i(cpu_wr_i),
   .cpu_done_o(cpu_done_o), .bus_start_o(bus_start_o), .bus_req_o(bus_req_o),
   .bus_burst_o(bus_burst_o), .snoop_hit_modified_o(snoop_hit_modified_o),
   .backoff_o(backoff_o), .writeback_mode_o(writeback_mode_o));

// file: bus_memory_model.sv
// partner: external memory answering the block's bus cycles
module bus_memory_model
   import line_state_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic bus_start_i,
   input wire bus_req_type bus_req_i,
   input wire logic bus_burst_i,
   input wire logic [1:0] wait_i,
   output logic ready_n_o,
   output logic burst_ready_n_o,
   output logic [WORD_W-1:0] rdata_o,
   output int starts_o,
   output int writes_o
);
   logic [WORD_W-1:0] mem [logic [ADDR_W-1:0]];
   initial begin
      logic [ADDR_W-1:0] base;
      logic [ADDR_W-1:0] ad;
      logic wr;
      int n;
      ready_n_o = 1'b1;
      burst_ready_n_o = 1'b1;
      rdata_o = 32'h0;
      starts_o = 0;
      writes_o = 0;
      forever begin
         @(posedge sys_clk_i);
         if (nrst_i && bus_start_i) begin
            base = bus_req_i.addr;
            wr = bus_req_i.write_read;
            n = bus_burst_i ? WORDS : 1;
            starts_o++;
            if (wr) writes_o++;
            for (int b = 0; b < n; b++) begin
               // gap covers the block's two-stage ready sync
               repeat (3 + wait_i) @(posedge sys_clk_i);
               ad = (n == WORDS) ? {base[ADDR_W-1:WSEL_W], b[WSEL_W-1:0]} : base;
               if (wr) mem[ad] = bus_req_i.data;
               else rdata_o <= mem.exists(ad) ? mem[ad] : (32'h5a00_0000 ^ {2'h0, ad});
               if (n == WORDS) burst_ready_n_o <= 1'b0;
               else ready_n_o <= 1'b0;
               @(posedge sys_clk_i);
               ready_n_o <= 1'b1;
               burst_ready_n_o <= 1'b1;
               rdata_o <= ~rdata_o; // released data never keeps its value
            end
         end
      end
   end
endmodule

// file: writeback_cache_line_state_tb.sv
// bench: cpu traffic, fills, snoops and both cache modes
module writeback_cache_line_state_tb
   import line_state_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   access_type req = '0;
   logic policy = 1'b1;
   logic page_write_through_flag = 1'b0;
   logic snp = 1'b0;
   logic inv = 1'b0;
   logic [ADDR_W-1:0] snp_a = '0;
   logic [1:0] wait_r = 2'h0;
   logic done, rdy_n, burst_ready_n, hitm, boff, wbm, bstart, burst, supply;
   logic [WORD_W-1:0] rdata, bdata;
   bus_req_type breq;
   int starts, writes, failures = 0, cmp_count = 0, cyc = 0, seed = 32'h5ced;
   logic [WORD_W-1:0] exp_q [$];
   always #5 clk = ~clk;
   writeback_cache_line_state writeback_cache_line_state_i (.sys_clk_i(clk), .nrst_i(rst_n),
      .cpu_rd_i(rd), .cpu_wr_i(wr), .cpu_req_i(req), .cpu_done_o(done), .cpu_rdata_o(rdata),
      .bus_start_o(bstart), .bus_req_o(breq), .bus_burst_o(burst), .ready_n_i(rdy_n),
      .burst_ready_n_i(burst_ready_n), .bus_rdata_i(bdata), .line_policy_select_i(policy),
      .page_write_through_flag_i(page_write_through_flag), .snoop_start_i(snp), .snoop_inv_i(inv),
      .snoop_addr_i(snp_a), .snoop_hit_modified_o(hitm), .backoff_o(boff),
      .writeback_mode_o(wbm), .supply_level_indicator_o(supply));
   bus_memory_model bus_memory_model_i (.sys_clk_i(clk), .nrst_i(rst_n), .bus_start_i(bstart),
      .bus_req_i(breq), .bus_burst_i(burst), .wait_i(wait_r), .ready_n_o(rdy_n),
      .burst_ready_n_o(burst_ready_n), .rdata_o(bdata), .starts_o(starts), .writes_o(writes));
   function automatic logic [WORD_W-1:0] fw(input logic [ADDR_W-1:0] a);
      return 32'h5a00_0000 ^ {2'h0, a};
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         failures++;
         complete_run();
      end
   end
   always @(negedge clk) if (done === 1'b1 && rd === 1'b1) check("rdata", rdata, exp_q.pop_front());
   // for reads d carries the expected data
   task automatic op(input logic w, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
      int n;
      n = 0;
      if (!w) exp_q.push_back(d);
      @(posedge clk);
      wait_r <= 2'($random(seed));
      rd <= !w;
      wr <= w;
      req <= '{addr: a, data: d};
      do begin
         @(negedge clk);
         n++;
      end while (done !== 1'b1 && n < 500);
      if (n >= 500) failures++;
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic rd_op(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d, input int ns);
      int s0;
      s0 = starts;
      op(1'b0, a, d);
      check("bus cycles", starts - s0, ns);
   endtask
   task automatic wr_op(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d, input int nb);
      int w0;
      w0 = writes;
      op(1'b1, a, d);
      check("bus writes", writes - w0, nb);
   endtask
   task automatic reset_with(input logic p);
      @(posedge clk);
      rst_n <= 1'b0;
      policy <= p;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   task automatic snoop(input logic [ADDR_W-1:0] a, input logic iv, input int hits);
      int h;
      int w0;
      logic bo;
      h = 0;
      bo = 1'b0;
      w0 = writes;
      @(posedge clk);
      snp <= 1'b1;
      inv <= iv;
      snp_a <= a;
      @(posedge clk);
      snp <= 1'b0;
      inv <= 1'b0;
      // as the backed-off master, stay off the bus until released
      for (int i = 0; i < 100 && !(bo && boff !== 1'b1); i++) begin
         @(negedge clk);
         if (hitm === 1'b1) h++;
         if (boff === 1'b1) bo = 1'b1;
      end
      check("snoop hit", h, hits);
      check("snoop writeback", writes - w0, hits);
   endtask
   initial begin
      logic [WORD_W-1:0] d1;
      logic [WORD_W-1:0] d2;
      reset_with(1'b1);
      check("mode", wbm, 1);
      check("supply", supply, 0);
      d1 = $random(seed);
      d2 = $random(seed);
      rd_op(30'h100, fw(30'h100), 1);
      wr_op(30'h100, d1, 0);
      rd_op(30'h100, d1, 0);
      rd_op(30'h120, fw(30'h120), 2);
      rd_op(30'h100, d1, 1);
      rd_op(30'h101, fw(30'h101), 0);
      policy <= 1'b0;
      rd_op(30'h104, fw(30'h104), 1);
      wr_op(30'h104, d1, 1);
      rd_op(30'h104, d1, 0);
      policy <= 1'b1;
      page_write_through_flag <= 1'b1;
      rd_op(30'h108, fw(30'h108), 1);
      wr_op(30'h108, d2, 1);
      page_write_through_flag <= 1'b0;
      wr_op(30'h10c, d1, 1);
      rd_op(30'h10c, d1, 1);
      wr_op(30'h10c, d2, 0);
      snoop(30'h10c, 1'b1, 1);
      rd_op(30'h10c, d2, 1);
      snoop(30'h10c, 1'b0, 0);
      wr_op(30'h10c, d1, 1);
      snoop(30'h110, 1'b1, 0);
      reset_with(1'b0);
      check("mode", wbm, 0);
      policy <= 1'b1;
      rd_op(30'h104, d1, 1);
      wr_op(30'h104, d2, 1);
      rd_op(30'h104, d2, 0);
      complete_run();
   end
endmodule
